// *** rtl/vfs_pkg.sv ***
package vfs_pkg;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] ADDR_DET_FMT  = 8'h00;
  localparam logic [7:0] ADDR_LOCK     = 8'h01;
  localparam logic [7:0] ADDR_MAN_FMT  = 8'h10;
  localparam logic [7:0] ADDR_GAIN_OVR = 8'h11;
  localparam logic [7:0] ADDR_EQ_GLB   = 8'h12;
  localparam logic [7:0] ADDR_EQ_BAND  = 8'h13;
  localparam logic [7:0] ADDR_AIN_CTL  = 8'h14;

  // ************************************************
  // writable register table
  // ************************************************
  localparam int NUM_RW        = 5;
  localparam int IDX_MAN_FMT   = 0;
  localparam int IDX_GAIN_OVR  = 1;
  localparam int IDX_EQ_GLB    = 2;
  localparam int IDX_EQ_BAND   = 3;
  localparam int IDX_AIN_CTL   = 4;
  localparam logic [7:0] RW_ADDR [NUM_RW] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
  localparam logic [7:0] RW_MASK [NUM_RW] = '{8'hff, 8'h7f, 8'h1f, 8'h37, 8'h03};
  localparam logic [7:0] RW_RST  [NUM_RW] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] STAT_RST = 8'h00;

  // ************************************************
  // field positions
  // ************************************************
  localparam int STD_MSB  = 7;
  localparam int STD_LSB  = 6;
  localparam int REF_MSB  = 5;
  localparam int REF_LSB  = 4;
  localparam int VID_BIT  = 3;
  localparam int RES_MSB  = 2;
  localparam int RES_LSB  = 0;
  localparam int VAR_BIT  = 3;
  localparam int GAIN_MSB = 6;
  localparam int GAIN_LSB = 4;
  localparam int OVR_STD  = 2;
  localparam int OVR_REF  = 1;
  localparam int OVR_RES  = 0;
  localparam int EQG_MSB  = 4;
  localparam int EQL_MSB  = 5;
  localparam int EQL_LSB  = 4;
  localparam int EQH_MSB  = 2;
  localparam int AIN_MSB  = 1;
  localparam int LK_RSV   = 4;

  // ************************************************
  // two-wire port
  // ************************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h5c; // arbitrary value

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK, S_WR, S_WR_ACK, S_RD, S_RD_ACK
  } vfs_state_e;

endpackage : vfs_pkg

// *** rtl/vfs_line_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none
module vfs_line_sampler (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det,
  output logic      sda_bit
);

  // ************************************************
  // line history, idle high
  // ************************************************
  logic [2:0] scl_sh;
  logic [2:0] sda_sh;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_sh <= 3'h7;
      sda_sh <= 3'h7;
    end
    else
    begin
      scl_sh <= {scl_sh[1:0], scl_in};
      sda_sh <= {sda_sh[1:0], sda_in};
    end
  end

  // ************************************************
  // edge and bus condition decode
  // ************************************************
  assign scl_rise  = scl_sh[1] & ~scl_sh[2];
  assign scl_fall  = ~scl_sh[1] & scl_sh[2];
  assign start_det = scl_sh[1] & scl_sh[2] & ~sda_sh[1] & sda_sh[2];
  assign stop_det  = scl_sh[1] & scl_sh[2] & sda_sh[1] & ~sda_sh[2];
  assign sda_bit   = sda_sh[1];

endmodule : vfs_line_sampler
`default_nettype wire

// *** rtl/vfs_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - detected standard code in bits 7:6
// - detected refresh rate code, read only
// - video present flag, read only
// - detected resolution code, read only
// - standard detection lock in lock bit 7
// - gain loop lock flag, read only
// - clamp loop lock in lock bit 5
// - horizontal line loop lock in bit 3
// - chroma fine lock bit 2, coarse 1
// - chroma present flag in lock bit 0
// - writable forced standard, bits 7:6
// - writable forced refresh rate, bits 5:4
// - variant bit for standard three
// - writable forced resolution, bits 2:0
// - override enables pick manual over detected
// - three-bit input gain select, bits 6:4
// - five-bit equalizer global gain
// - equalizer low band gain, bits 5:4
// - equalizer high band gain, bits 2:0
// - analog input select, bits 1:0
module vfs_regs
  import vfs_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [1:0] detected_standard,
  input  wire logic [1:0] detected_refresh_rate,
  input  wire logic       video_present,
  input  wire logic [2:0] detected_resolution,
  input  wire logic       standard_locked,
  input  wire logic       gain_loop_locked,
  input  wire logic       clamp_loop_locked,
  input  wire logic       hline_loop_locked,
  input  wire logic       chroma_fine_locked,
  input  wire logic       chroma_coarse_locked,
  input  wire logic       chroma_present,
  output logic [1:0]      active_standard,
  output logic [1:0]      active_refresh_rate,
  output logic [2:0]      active_resolution,
  output logic            standard3_variant,
  output logic [2:0]      input_gain_select,
  output logic [4:0]      equalizer_global_gain,
  output logic [1:0]      equalizer_low_band_gain,
  output logic [2:0]      equalizer_high_band_gain,
  output logic [1:0]      analog_input_select
);

  // ************************************************
  // declarations
  // ************************************************
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_bit;
  vfs_state_e state_reg;
  vfs_state_e state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic       oe_reg;
  logic       oe_next;
  logic       mack_reg;
  logic       mack_next;
  logic       wr_pulse;
  logic [7:0] det_fmt_reg;
  logic [7:0] lock_reg;
  logic [7:0] rw_reg [NUM_RW];
  logic [7:0] rd_rw [NUM_RW];
  logic [1:0] act_std_reg;
  logic [1:0] act_ref_reg;
  logic [2:0] act_res_reg;
  logic       past_live;
  wire  [7:0] man_fmt   = rw_reg[IDX_MAN_FMT];
  wire  [7:0] gain_ovr  = rw_reg[IDX_GAIN_OVR];
  wire        addr_hit  = (sh_reg[7:1] == DEV_ADDR);
  wire        byte_end  = scl_fall && (cnt_reg == BYTE_BITS);
  wire  [7:0] rd_det    = (ptr_reg == ADDR_DET_FMT) ? det_fmt_reg : 8'h00;
  wire  [7:0] rd_lock   = (ptr_reg == ADDR_LOCK) ? lock_reg : 8'h00;
  wire  [7:0] rd_data   = rd_det | rd_lock | rd_rw[0] | rd_rw[1] | rd_rw[2] | rd_rw[3] | rd_rw[4];

  // ************************************************
  // two-wire line sampling
  // ************************************************
  vfs_line_sampler u_sampler (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .sda_bit   (sda_bit)
  );

  // ************************************************
  // two-wire protocol engine
  // ************************************************
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    ptr_next   = ptr_reg;
    oe_next    = oe_reg;
    mack_next  = mack_reg;
    wr_pulse   = 1'b0;
    if (stop_det)
    begin
      state_next = S_IDLE;
      oe_next    = 1'b0;
    end
    else if (start_det)
    begin
      state_next = S_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          cnt_next = 4'h0;
        end
        S_ADDR, S_PTR, S_WR:
        begin
          if (scl_rise)
          begin
            sh_next  = {sh_reg[6:0], sda_bit};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_next = 4'h0;
            if (state_reg == S_ADDR)
            begin
              state_next = addr_hit ? S_ADDR_ACK : S_IDLE;
              oe_next    = addr_hit;
            end
            else if (state_reg == S_PTR)
            begin
              state_next = S_PTR_ACK;
              oe_next    = 1'b1;
              ptr_next   = sh_reg;
            end
            else
            begin
              state_next = S_WR_ACK;
              oe_next    = 1'b1;
              wr_pulse   = 1'b1;
              ptr_next   = ptr_reg + 8'h01;
            end
          end
        end
        S_ADDR_ACK:
        begin
          if (scl_fall && sh_reg[0])
          begin
            state_next = S_RD;
            sh_next    = rd_data;
            oe_next    = ~rd_data[7];
            cnt_next   = 4'h1;
          end
          else if (scl_fall)
          begin
            state_next = S_PTR;
            oe_next    = 1'b0;
          end
        end
        S_PTR_ACK, S_WR_ACK:
        begin
          if (scl_fall)
          begin
            state_next = S_WR;
            oe_next    = 1'b0;
          end
        end
        S_RD:
        begin
          if (byte_end)
          begin
            state_next = S_RD_ACK;
            oe_next    = 1'b0;
            cnt_next   = 4'h0;
            ptr_next   = ptr_reg + 8'h01;
          end
          else if (scl_fall)
          begin
            sh_next  = {sh_reg[6:0], 1'b0};
            oe_next  = ~sh_reg[6];
            cnt_next = cnt_reg + 4'h1;
          end
        end
        S_RD_ACK:
        begin
          if (scl_rise)
          begin
            mack_next = ~sda_bit;
          end
          else if (scl_fall && mack_reg)
          begin
            state_next = S_RD;
            sh_next    = rd_data;
            oe_next    = ~rd_data[7];
            cnt_next   = 4'h1;
          end
          else if (scl_fall)
          begin
            state_next = S_IDLE;
          end
        end
        default:
        begin
          state_next = S_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= S_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      oe_reg    <= 1'b0;
      mack_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      ptr_reg   <= ptr_next;
      oe_reg    <= oe_next;
      mack_reg  <= mack_next;
    end
  end

  // ************************************************
  // writable registers
  // ************************************************
  for (genvar i = 0; i < NUM_RW; i++)
  begin : g_rw
    wire hit = (ptr_reg == RW_ADDR[i]);
    assign rd_rw[i] = hit ? rw_reg[i] : 8'h00;
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
        rw_reg[i] <= RW_RST[i];
      else if (wr_pulse && hit)
        rw_reg[i] <= sh_reg & RW_MASK[i];
    end
  end

  // ************************************************
  // status capture and active format
  // ************************************************
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      det_fmt_reg <= STAT_RST;
      lock_reg    <= STAT_RST;
      act_std_reg <= 2'h0;
      act_ref_reg <= 2'h0;
      act_res_reg <= 3'h0;
      past_live   <= 1'b0;
    end
    else
    begin
      det_fmt_reg <= {detected_standard, detected_refresh_rate, video_present, detected_resolution};
      lock_reg    <= {standard_locked, gain_loop_locked, clamp_loop_locked, 1'b0, hline_loop_locked,
                      chroma_fine_locked, chroma_coarse_locked, chroma_present};
      act_std_reg <= gain_ovr[OVR_STD] ? man_fmt[STD_MSB:STD_LSB] : detected_standard;
      act_ref_reg <= gain_ovr[OVR_REF] ? man_fmt[REF_MSB:REF_LSB] : detected_refresh_rate;
      act_res_reg <= gain_ovr[OVR_RES] ? man_fmt[RES_MSB:RES_LSB] : detected_resolution;
      past_live   <= 1'b1;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign sda_out                  = 1'b0;
  assign sda_oe                   = oe_reg;
  assign active_standard          = act_std_reg;
  assign active_refresh_rate      = act_ref_reg;
  assign active_resolution        = act_res_reg;
  assign standard3_variant        = man_fmt[VAR_BIT];
  assign input_gain_select        = gain_ovr[GAIN_MSB:GAIN_LSB];
  assign equalizer_global_gain    = rw_reg[IDX_EQ_GLB][EQG_MSB:0];
  assign equalizer_low_band_gain  = rw_reg[IDX_EQ_BAND][EQL_MSB:EQL_LSB];
  assign equalizer_high_band_gain = rw_reg[IDX_EQ_BAND][EQH_MSB:0];
  assign analog_input_select      = rw_reg[IDX_AIN_CTL][AIN_MSB:0];

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  wire wr_man    = wr_pulse && (ptr_reg == ADDR_MAN_FMT);
  wire wr_gain   = wr_pulse && (ptr_reg == ADDR_GAIN_OVR);
  wire wr_eqb    = wr_pulse && (ptr_reg == ADDR_EQ_BAND);

  std_capture_a: assert property (past_live |-> det_fmt_reg[7:6] == $past(detected_standard))
    else $error("detected standard not captured");
  ref_capture_a: assert property (past_live |-> det_fmt_reg[5:4] == $past(detected_refresh_rate))
    else $error("refresh rate not captured");
  video_flag_a: assert property (past_live |-> det_fmt_reg[3] == $past(video_present))
    else $error("video present flag wrong");
  res_capture_a: assert property (past_live |-> det_fmt_reg[2:0] == $past(detected_resolution))
    else $error("resolution not captured");
  std_lock_a: assert property (past_live |-> lock_reg[7] == $past(standard_locked))
    else $error("standard lock bit late");
  gain_lock_a: assert property (past_live |-> lock_reg[6] == $past(gain_loop_locked))
    else $error("gain lock bit wrong");
  clamp_lock_a: assert property (past_live |-> lock_reg[5] == $past(clamp_loop_locked))
    else $error("clamp lock bit wrong");
  hline_lock_a: assert property (past_live |-> lock_reg[3] == $past(hline_loop_locked) && !lock_reg[LK_RSV])
    else $error("line lock bit wrong");
  chroma_lock_a: assert property (past_live |-> lock_reg[2:1] == {$past(chroma_fine_locked),
                                  $past(chroma_coarse_locked)})
    else $error("chroma lock bits wrong");
  chroma_det_a: assert property (past_live |-> lock_reg[0] == $past(chroma_present))
    else $error("chroma present bit wrong");
  man_std_wr_a: assert property (wr_man |=> man_fmt[7:6] == $past(sh_reg[7:6]))
    else $error("forced standard not written");
  man_ref_wr_a: assert property (wr_man |=> man_fmt[5:4] == $past(sh_reg[5:4]) ##1
                                 (!gain_ovr[OVR_REF] || active_refresh_rate == $past(man_fmt[5:4])))
    else $error("forced refresh rate not written");
  variant_wr_a: assert property (wr_man |=> standard3_variant == $past(sh_reg[3]))
    else $error("variant bit not written");
  man_res_wr_a: assert property (wr_man |=> man_fmt[2:0] == $past(sh_reg[2:0]))
    else $error("forced resolution not written");
  override_a: assert property (gain_ovr[OVR_STD] && $stable(gain_ovr) ##1 $stable(man_fmt)
                               |-> active_standard == $past(man_fmt[7:6]))
    else $error("override ignored");
  gain_wr_a: assert property (wr_gain |=> input_gain_select == $past(sh_reg[6:4]) && !gain_ovr[7])
    else $error("input gain not written");
  eq_glb_wr_a: assert property (wr_pulse && ptr_reg == ADDR_EQ_GLB |=> equalizer_global_gain ==
                                $past(sh_reg[4:0]))
    else $error("global gain not written");
  eq_low_wr_a: assert property (wr_eqb |=> equalizer_low_band_gain == $past(sh_reg[5:4]))
    else $error("low band gain not written");
  eq_high_wr_a: assert property (wr_eqb |=> equalizer_high_band_gain == $past(sh_reg[2:0]))
    else $error("high band gain not written");
  ain_wr_a: assert property (wr_pulse && ptr_reg == ADDR_AIN_CTL |=> analog_input_select ==
                             $past(sh_reg[1:0]) && rw_reg[IDX_AIN_CTL][7:2] == 6'h00)
    else $error("input select not written");
  rsv_read_a: assert property (ptr_reg > ADDR_LOCK && ptr_reg < ADDR_MAN_FMT |-> rd_data == 8'h00)
    else $error("unmapped read not zero");

  rd_cov: cover property (state_reg == S_RD_ACK ##[1:400] state_reg == S_RD);
  wr_cov: cover property (wr_gain ##1 gain_ovr[OVR_RES]);
  nack_cov: cover property (state_reg == S_ADDR && byte_end && !addr_hit);
  ovr_cov: cover property (gain_ovr[OVR_STD] && active_standard != detected_standard);

endmodule : vfs_regs
`default_nettype wire

// *** verification/vfs_decoder_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// decoder core status source
// ************************************************
module vfs_decoder_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [14:0] stat_word,
  output logic [1:0]       detected_standard,
  output logic [1:0]       detected_refresh_rate,
  output logic             video_present,
  output logic [2:0]       detected_resolution,
  output logic             standard_locked,
  output logic             gain_loop_locked,
  output logic             clamp_loop_locked,
  output logic             hline_loop_locked,
  output logic             chroma_fine_locked,
  output logic             chroma_coarse_locked,
  output logic             chroma_present
);
  logic [14:0] stat_reg;
  // loops unlocked and nothing detected while in reset
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      stat_reg <= 15'h0000;
    else
      stat_reg <= stat_word;
  end
  assign {detected_standard, detected_refresh_rate, video_present, detected_resolution,
          standard_locked, gain_loop_locked, clamp_loop_locked, hline_loop_locked,
          chroma_fine_locked, chroma_coarse_locked, chroma_present} = stat_reg;
endmodule : vfs_decoder_model
`default_nettype wire

// *** verification/video_input_format_status_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ************************************************
// bench top
// ************************************************
module video_input_format_status_regs_tb_top;
  import vfs_pkg::*;
  localparam logic [7:0] DEVW = {DEV_ADDR_DEF, 1'b0};
  logic        mclk, rst_b, scl, m_oe, k_n;
  logic [14:0] stat_word;
  logic [15:0] lf;
  logic [7:0]  mreg [256];
  int          fails, cmp_count;
  wire  logic  sda_out, sda_oe, standard3_variant;
  wire  logic  vp, s_lk, g_lk, c_lk, h_lk, f_lk, k_lk, c_pr;
  wire  logic [1:0] d_std, d_ref, active_standard, active_refresh_rate;
  wire  logic [1:0] equalizer_low_band_gain, analog_input_select;
  wire  logic [2:0] d_res, active_resolution, input_gain_select, equalizer_high_band_gain;
  wire  logic [4:0] equalizer_global_gain;
  // open drain line with pull-up
  wire  logic  sda = ~m_oe & (sda_oe ? sda_out : 1'b1);

  vfs_decoder_model vfs_decoder_model_i (.mclk(mclk), .rst_b(rst_b), .stat_word(stat_word),
    .detected_standard(d_std), .detected_refresh_rate(d_ref), .video_present(vp),
    .detected_resolution(d_res), .standard_locked(s_lk), .gain_loop_locked(g_lk),
    .clamp_loop_locked(c_lk), .hline_loop_locked(h_lk), .chroma_fine_locked(f_lk),
    .chroma_coarse_locked(k_lk), .chroma_present(c_pr));

  vfs_regs vfs_regs_i (.mclk(mclk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .detected_standard(d_std), .detected_refresh_rate(d_ref), .video_present(vp),
    .detected_resolution(d_res), .standard_locked(s_lk), .gain_loop_locked(g_lk),
    .clamp_loop_locked(c_lk), .hline_loop_locked(h_lk), .chroma_fine_locked(f_lk),
    .chroma_coarse_locked(k_lk), .chroma_present(c_pr), .active_standard(active_standard),
    .active_refresh_rate(active_refresh_rate), .active_resolution(active_resolution),
    .standard3_variant(standard3_variant), .input_gain_select(input_gain_select),
    .equalizer_global_gain(equalizer_global_gain), .equalizer_low_band_gain(equalizer_low_band_gain),
    .equalizer_high_band_gain(equalizer_high_band_gain), .analog_input_select(analog_input_select));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == ADDR_DET_FMT)
      return stat_word[14:7];
    if (a == ADDR_LOCK)
      return {stat_word[6:4], 1'b0, stat_word[3:0]};
    return mreg[a];
  endfunction : exp_rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic half;
    repeat (8) @(negedge mclk);
  endtask : half

  task automatic i2c_start;
    m_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    m_oe = 1'b1;
    half();
    scl = 1'b0;
  endtask : i2c_start

  task automatic i2c_stop;
    half();
    m_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    m_oe = 1'b0;
    half();
  endtask : i2c_stop

  task automatic wbit(input logic b);
    repeat (3) @(negedge mclk);
    m_oe = ~b;
    half();
    scl = 1'b1;
    half();
    scl = 1'b0;
  endtask : wbit

  task automatic rbit(output logic b);
    repeat (3) @(negedge mclk);
    m_oe = 1'b0;
    half();
    scl = 1'b1;
    repeat (4) @(negedge mclk);
    b = sda;
    repeat (4) @(negedge mclk);
    scl = 1'b0;
  endtask : rbit

  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(ack_n);
  endtask : wbyte

  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(nack);
  endtask : rbyte

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic k1, k2, k3;
    i2c_start();
    wbyte(DEVW, k1);
    wbyte(a, k2);
    wbyte(d, k3);
    i2c_stop();
    chk({7'h00, k1 | k2 | k3}, 8'h00, "write ack");
    for (int i = 0; i < NUM_RW; i++) if (RW_ADDR[i] == a) mreg[a] = d & RW_MASK[i];
  endtask : write_reg

  task automatic read_chk(input logic [7:0] a);
    logic       k1, k2, k3;
    logic [7:0] d, d2;
    i2c_start();
    wbyte(DEVW, k1);
    wbyte(a, k2);
    i2c_start();
    wbyte(DEVW | 8'h01, k3);
    rbyte(d, 1'b0);
    rbyte(d2, 1'b1);
    i2c_stop();
    chk({7'h00, k1 | k2 | k3}, 8'h00, "read ack");
    chk(d, exp_rd(a), $sformatf("read %h", a));
    chk(d2, exp_rd(a + 8'h01), $sformatf("read next %h", a + 8'h01));
  endtask : read_chk

  task automatic check_outs;
    logic [3:0] o;
    logic [7:0] m;
    o = mreg[ADDR_GAIN_OVR][3:0];
    m = mreg[ADDR_MAN_FMT];
    chk({6'h00, active_standard}, {6'h00, o[OVR_STD] ? m[7:6] : stat_word[14:13]}, "std");
    chk({6'h00, active_refresh_rate}, {6'h00, o[OVR_REF] ? m[5:4] : stat_word[12:11]}, "ref");
    chk({5'h00, active_resolution}, {5'h00, o[OVR_RES] ? m[2:0] : stat_word[9:7]}, "res");
    chk({7'h00, standard3_variant}, {7'h00, m[3]}, "variant");
    chk({5'h00, input_gain_select}, {5'h00, mreg[ADDR_GAIN_OVR][6:4]}, "gain");
    chk({3'h0, equalizer_global_gain}, mreg[ADDR_EQ_GLB], "eq glb");
    chk({6'h00, equalizer_low_band_gain}, {6'h00, mreg[ADDR_EQ_BAND][5:4]}, "eq low");
    chk({5'h00, equalizer_high_band_gain}, {5'h00, mreg[ADDR_EQ_BAND][2:0]}, "eq high");
    chk({6'h00, analog_input_select}, mreg[ADDR_AIN_CTL], "ain");
  endtask : check_outs

  task automatic new_status;
    lf = lfsr_next(lf);
    stat_word = {lf[14:10], 3'(lf % 5), lf[6:0]};
    repeat (4) @(negedge mclk);
  endtask : new_status

  task automatic final_report;
    $display("counts: %0d compares, %0d fails", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (80000) @(posedge mclk);
    fails++;
    final_report();
  end

  initial
  begin
    scl = 1'b1;
    m_oe = 1'b0;
    rst_b = 1'b0;
    stat_word = 15'h0000;
    lf = 16'h0030;
    fails = 0;
    cmp_count = 0;
    foreach (mreg[i]) mreg[i] = 8'h00;
    repeat (16) @(negedge mclk);
    rst_b = 1'b1;
    repeat (6) @(negedge mclk);
    foreach (RW_ADDR[i]) read_chk(RW_ADDR[i]);
    read_chk(ADDR_DET_FMT);
    read_chk(ADDR_LOCK);
    read_chk(8'h20);
    check_outs();
    $display("test reset values done");
    for (int i = 0; i < NUM_RW; i++)
    begin
      repeat (2)
      begin
        lf = lfsr_next(lf);
        write_reg(RW_ADDR[i], lf[7:0]);
        read_chk(RW_ADDR[i]);
        check_outs();
      end
    end
    $display("test read write done");
    write_reg(ADDR_DET_FMT, 8'hff);
    write_reg(ADDR_LOCK, 8'hff);
    repeat (5)
    begin
      new_status();
      read_chk(ADDR_DET_FMT);
      read_chk(ADDR_LOCK);
    end
    $display("test status done");
    i2c_start();
    wbyte(DEVW ^ 8'h02, k_n);
    wbyte(ADDR_EQ_GLB, k_n);
    wbyte(mreg[ADDR_EQ_GLB] ^ 8'h1f, k_n);
    i2c_stop();
    chk({7'h00, k_n}, 8'h01, "foreign address acked");
    check_outs();
    $display("test foreign address done");
    for (int o = 0; o < 8; o++)
    begin
      lf = lfsr_next(lf);
      write_reg(ADDR_MAN_FMT, {lf[7:3], 3'(lf % 4)});
      write_reg(ADDR_GAIN_OVR, {1'b0, lf[10:8], 4'(o)});
      check_outs();
      new_status();
      check_outs();
    end
    $display("test override done");
    final_report();
  end
endmodule : video_input_format_status_regs_tb_top
`default_nettype wire
